// *** hdl/collide_pkg.sv ***
package collide_pkg;

  // baud reload field and counter
  localparam int         RELOAD_MSB   = 6;
  localparam int         RELOAD_W     = RELOAD_MSB + 1;
  localparam logic [6:0] CNT_RESET    = 7'h00;
  localparam logic [6:0] CNT_ZERO     = 7'h00;
  localparam logic [6:0] CNT_STEP     = 7'h01;

  // line drive and level reset values
  localparam logic       LINE_RELEASE = 1'b0;  // output enable off: line floats
  localparam logic       LINE_PULL    = 1'b1;  // output enable on: line pulled low
  localparam logic       LINE_LOW     = 1'b0;  // value put on a driven line
  localparam logic       LVL_IDLE     = 1'b1;  // idle bus level after reset
  localparam logic       FLAG_RESET   = 1'b0;
  localparam logic       EN_RESET     = 1'b0;
  localparam logic       TGL_RESET    = 1'b0;

  // condition sequencer states, one-hot
  typedef enum logic [12:0] {
    ST_IDLE   = 13'h0001,
    ST_S_CHK  = 13'h0002,
    ST_S_CNT1 = 13'h0004,
    ST_S_CNT2 = 13'h0008,
    ST_R_REL  = 13'h0010,
    ST_R_CNT1 = 13'h0020,
    ST_R_SCLH = 13'h0040,
    ST_R_CNT2 = 13'h0080,
    ST_R_CNT3 = 13'h0100,
    ST_P_SDAL = 13'h0200,
    ST_P_SCLH = 13'h0400,
    ST_P_CNT1 = 13'h0800,
    ST_P_CNT2 = 13'h1000
  } cond_state_t;

endpackage : collide_pkg

// *** hdl/link_if.sv ***
`timescale 1ns/1ns
// bus levels and stop events seen on the link clock
interface link_if;
  logic sda_lvl;
  logic scl_lvl;
  logic stop_tgl;

  modport mon (output sda_lvl, output scl_lvl, output stop_tgl);
  modport sys (input sda_lvl, input scl_lvl, input stop_tgl);
endinterface : link_if

// *** hdl/link_monitor.sv ***
`timescale 1ns/1ns
module link_monitor
  import collide_pkg::*;
(
  input  wire logic clk_link,
  input  wire logic rst_n,
  input  wire logic sda_in,
  input  wire logic scl_in,
  link_if.mon       lk
);

  logic rst_m_r;
  logic rst_link_n_r;
  logic sda_m_r;
  logic scl_m_r;
  logic sda_r;
  logic scl_r;
  logic sda_d_r;
  logic tgl_r;

  // reset and pin synchronisers on the link clock
  always_ff @(posedge clk_link) begin
    rst_m_r      <= rst_n;
    rst_link_n_r <= rst_m_r;
    sda_m_r      <= sda_in;
    scl_m_r      <= scl_in;
  end

  // a stop is sda rising while scl stays high
  wire stop_seen = sda_r & ~sda_d_r & scl_r;

  // sampled levels and stop toggle
  always_ff @(posedge clk_link) begin
    if (!rst_link_n_r) begin
      sda_r   <= LVL_IDLE;
      scl_r   <= LVL_IDLE;
      sda_d_r <= LVL_IDLE;
      tgl_r   <= TGL_RESET;
    end else begin
      sda_r   <= sda_m_r;
      scl_r   <= scl_m_r;
      sda_d_r <= sda_r;
      tgl_r   <= tgl_r ^ stop_seen;
    end
  end

  assign lk.sda_lvl  = sda_r;
  assign lk.scl_lvl  = scl_r;
  assign lk.stop_tgl = tgl_r;

endmodule : link_monitor

// *** hdl/baud_counter.sv ***
`timescale 1ns/1ns
module baud_counter
  import collide_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                load,
  input  wire logic                halt,
  input  wire logic [RELOAD_W-1:0] reload,
  output logic      [RELOAD_W-1:0] count,
  output logic                     expire
);

  logic [RELOAD_W-1:0] cnt_r;
  logic                run_r;

  // expiry is the cycle the running count sits at zero
  wire at_zero = (cnt_r == CNT_ZERO);
  wire cnt_dec = run_r & ~at_zero;

  // load wins over counting; halt stops a count in flight
  always_ff @(posedge clk_sys) begin
    if (!rst_n || halt) begin
      cnt_r <= CNT_RESET;
      run_r <= 1'b0;
    end else if (load) begin
      cnt_r <= reload;
      run_r <= 1'b1;
    end else begin
      cnt_r <= cnt_dec ? cnt_r - CNT_STEP : cnt_r;
      run_r <= cnt_dec;
    end
  end

  assign count  = cnt_r;
  assign expire = run_r & at_zero;

endmodule : baud_counter

// *** hdl/cond_collide.sv ***
`timescale 1ns/1ns
module cond_collide
  import collide_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                clk_link,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic                scl_in,
  output logic                     scl_out,
  output logic                     scl_oe,
  input  wire logic [7:0]          baud_reload_value,
  input  wire logic                start_req,
  input  wire logic                rstart_req,
  input  wire logic                stop_req,
  input  wire logic                clear_collision,
  input  wire logic                clear_irq,
  output logic                     start_en,
  output logic                     rstart_en,
  output logic                     stop_en,
  output logic                     bus_collision_flag,
  output logic                     serial_port_irq_flag
);

  link_if lk ();

  cond_state_t         state_r;
  cond_state_t         state_nxt;
  logic                sda_oe_r;
  logic                sda_oe_nxt;
  logic                scl_oe_r;
  logic                scl_oe_nxt;
  logic                sda_out_r;
  logic                scl_out_r;
  logic                start_en_r;
  logic                rstart_en_r;
  logic                stop_en_r;
  logic                collision_r;
  logic                irq_r;
  logic                sda_m_r;
  logic                scl_m_r;
  logic                tgl_m_r;
  logic                sda_s;
  logic                scl_s;
  logic                tgl_s_r;
  logic                tgl_d_r;
  logic                cnt_load;
  logic                collide;
  logic                done_any;
  logic                expire;
  logic [RELOAD_W-1:0] count;

  // pin sampling and stop detection on the link clock
  link_monitor u_mon (
    .clk_link (clk_link),
    .rst_n    (rst_n),
    .sda_in   (sda_in),
    .scl_in   (scl_in),
    .lk       (lk.mon)
  );

  // phase timing from the low seven reload bits
  baud_counter u_baud (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .load    (cnt_load),
    .halt    (collide),
    .reload  (baud_reload_value[RELOAD_MSB:0]),
    .count   (count),
    .expire  (expire)
  );

  // link levels and stop toggle cross into the system clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sda_m_r <= LVL_IDLE;
      scl_m_r <= LVL_IDLE;
      tgl_m_r <= TGL_RESET;
      sda_s   <= LVL_IDLE;
      scl_s   <= LVL_IDLE;
      tgl_s_r <= TGL_RESET;
      tgl_d_r <= TGL_RESET;
    end else begin
      sda_m_r <= lk.sda_lvl;
      scl_m_r <= lk.scl_lvl;
      tgl_m_r <= lk.stop_tgl;
      sda_s   <= sda_m_r;
      scl_s   <= scl_m_r;
      tgl_s_r <= tgl_m_r;
      tgl_d_r <= tgl_s_r;
    end
  end

  // request acceptance and event decode
  wire is_idle   = (state_r == ST_IDLE);
  wire any_en    = start_en_r | rstart_en_r | stop_en_r;
  wire req_ok    = is_idle & ~any_en;
  wire stop_evt  = tgl_s_r ^ tgl_d_r;
  wire done_s    = (state_r == ST_S_CNT2) & expire;
  wire done_r    = (state_r == ST_R_CNT3) & expire;
  wire done_p    = (state_r == ST_P_CNT2) & expire & sda_s;
  wire sda_low   = ~sda_s;
  wire scl_low   = ~scl_s;

  // condition sequencer: next state, line drive and counter loads
  always_comb begin
    state_nxt  = state_r;
    sda_oe_nxt = sda_oe_r;
    scl_oe_nxt = scl_oe_r;
    cnt_load   = 1'b0;
    collide    = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (start_en_r) begin
          state_nxt  = ST_S_CHK;
          sda_oe_nxt = LINE_RELEASE;
          scl_oe_nxt = LINE_RELEASE;
        end else if (rstart_en_r) begin
          state_nxt  = ST_R_REL;
          sda_oe_nxt = LINE_RELEASE;
          scl_oe_nxt = LINE_PULL;
        end else if (stop_en_r) begin
          state_nxt  = ST_P_SDAL;
          sda_oe_nxt = LINE_PULL;
          scl_oe_nxt = LINE_PULL;
        end
      end
      ST_S_CHK: begin
        if (sda_low || scl_low) begin
          collide = 1'b1;
        end else begin
          cnt_load  = 1'b1;
          state_nxt = ST_S_CNT1;
        end
      end
      ST_S_CNT1: begin
        if (scl_low && sda_s) begin
          collide = 1'b1;
        end else if (sda_low || expire) begin
          cnt_load   = 1'b1;
          sda_oe_nxt = LINE_PULL;
          state_nxt  = ST_S_CNT2;
        end
      end
      ST_S_CNT2: begin
        if (expire) begin
          scl_oe_nxt = LINE_PULL;
          state_nxt  = ST_IDLE;
        end
      end
      ST_R_REL: begin
        if (sda_s) begin
          cnt_load  = 1'b1;
          state_nxt = ST_R_CNT1;
        end
      end
      ST_R_CNT1: begin
        if (expire) begin
          scl_oe_nxt = LINE_RELEASE;
          state_nxt  = ST_R_SCLH;
        end
      end
      ST_R_SCLH: begin
        if (scl_s && sda_low) begin
          collide = 1'b1;
        end else if (scl_s) begin
          cnt_load  = 1'b1;
          state_nxt = ST_R_CNT2;
        end
      end
      ST_R_CNT2: begin
        if (scl_low) begin
          collide = 1'b1;
        end else if (expire) begin
          sda_oe_nxt = LINE_PULL;
          cnt_load   = 1'b1;
          state_nxt  = ST_R_CNT3;
        end
      end
      ST_R_CNT3: begin
        if (expire) begin
          scl_oe_nxt = LINE_PULL;
          state_nxt  = ST_IDLE;
        end
      end
      ST_P_SDAL: begin
        if (sda_low) begin
          scl_oe_nxt = LINE_RELEASE;
          state_nxt  = ST_P_SCLH;
        end
      end
      ST_P_SCLH: begin
        if (scl_s) begin
          cnt_load  = 1'b1;
          state_nxt = ST_P_CNT1;
        end
      end
      ST_P_CNT1: begin
        if (scl_low) begin
          collide = 1'b1;
        end else if (expire) begin
          sda_oe_nxt = LINE_RELEASE;
          cnt_load   = 1'b1;
          state_nxt  = ST_P_CNT2;
        end
      end
      ST_P_CNT2: begin
        if (expire && sda_low) begin
          collide = 1'b1;
        end else if (expire) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt  = ST_IDLE;
        sda_oe_nxt = LINE_RELEASE;
        scl_oe_nxt = LINE_RELEASE;
      end
    endcase
    if (collide) begin
      state_nxt  = ST_IDLE;
      sda_oe_nxt = LINE_RELEASE;
      scl_oe_nxt = LINE_RELEASE;
    end
  end

  assign done_any = done_s | done_r | done_p;

  // sequencer state and line drive registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      sda_oe_r  <= LINE_RELEASE;
      scl_oe_r  <= LINE_RELEASE;
      sda_out_r <= LINE_LOW;
      scl_out_r <= LINE_LOW;
    end else begin
      state_r   <= state_nxt;
      sda_oe_r  <= sda_oe_nxt;
      scl_oe_r  <= scl_oe_nxt;
      sda_out_r <= LINE_LOW;
      scl_out_r <= LINE_LOW;
    end
  end

  // condition enables: set by a request in idle, cleared on finish or abort
  always_ff @(posedge clk_sys) begin
    if (!rst_n || collide) begin
      start_en_r  <= EN_RESET;
      rstart_en_r <= EN_RESET;
      stop_en_r   <= EN_RESET;
    end else begin
      start_en_r  <= (start_en_r & ~done_s) | (req_ok & start_req);
      rstart_en_r <= (rstart_en_r & ~done_r) | (req_ok & ~start_req & rstart_req);
      stop_en_r   <= (stop_en_r & ~done_p) | (req_ok & ~start_req & ~rstart_req & stop_req);
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      collision_r <= FLAG_RESET;
      irq_r       <= FLAG_RESET;
    end else begin
      collision_r <= collide | (collision_r & ~clear_collision);
      irq_r       <= stop_evt | done_any | (irq_r & ~clear_irq);
    end
  end

  assign sda_out              = sda_out_r;
  assign sda_oe               = sda_oe_r;
  assign scl_out              = scl_out_r;
  assign scl_oe               = scl_oe_r;
  assign start_en             = start_en_r;
  assign rstart_en            = rstart_en_r;
  assign stop_en              = stop_en_r;
  assign bus_collision_flag   = collision_r;
  assign serial_port_irq_flag = irq_r;

  // checks on the sequencer
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_start_busy_abort: assert property (
    (state_r == ST_S_CHK) && (sda_low || scl_low) |=> collision_r && is_idle && !start_en_r)
    else $error("start on busy bus not aborted");
  a_start_count_load: assert property (
    (state_r == ST_S_CHK) && sda_s && scl_s
      |=> (state_r == ST_S_CNT1) && count == $past(baud_reload_value[RELOAD_MSB:0]))
    else $error("start count not loaded from reload");
  a_start_scl_clash: assert property (
    (state_r == ST_S_CNT1) && scl_low && sda_s |=> collision_r && !sda_oe_r && !scl_oe_r)
    else $error("scl low in first start count not a collision");
  a_start_early_pull: assert property (
    (state_r == ST_S_CNT1) && sda_low && scl_s
      |=> sda_oe_r && !$rose(collision_r) ##0 count == $past(baud_reload_value[RELOAD_MSB:0]))
    else $error("early sda pull or reload missing");
  a_start_sda_expiry: assert property (
    (state_r == ST_S_CNT1) && expire && sda_s && scl_s |=> sda_oe_r && state_r == ST_S_CNT2)
    else $error("sda not pulled at first start expiry");
  a_start_second_cnt: assert property (
    (state_r == ST_S_CNT2) && expire |=> scl_oe_r && sda_oe_r && !start_en_r && !$rose(collision_r))
    else $error("start not completed at second expiry");
  a_rstart_scl_release: assert property (
    (state_r == ST_R_CNT1) && expire |=> !scl_oe_r && !sda_oe_r)
    else $error("scl not released after repeated start count");
  a_rstart_sda_clash: assert property (
    (state_r == ST_R_SCLH) && scl_s && sda_low |=> collision_r && !rstart_en_r)
    else $error("sda low at scl high not a collision");
  a_rstart_sda_fall: assert property (
    (state_r == ST_R_CNT2) && sda_low && scl_s && !expire |=> state_r == ST_R_CNT2)
    else $error("sda fall in repeated start taken as collision");
  a_rstart_scl_clash: assert property (
    (state_r == ST_R_CNT2) && scl_low |=> collision_r && is_idle)
    else $error("scl fall in repeated start not a collision");
  a_rstart_finish: assert property (
    (state_r == ST_R_CNT3) && expire |=> scl_oe_r && sda_oe_r && !rstart_en_r)
    else $error("repeated start not completed");
  a_stop_scl_release: assert property (
    (state_r == ST_P_SDAL) && sda_low |=> !scl_oe_r && sda_oe_r)
    else $error("scl not released once sda low in stop");
  a_stop_sda_clash: assert property (
    (state_r == ST_P_CNT2) && expire && sda_low |=> collision_r && !stop_en_r)
    else $error("sda low after stop timeout not a collision");
  a_stop_scl_clash: assert property (
    (state_r == ST_P_CNT1) && scl_low |=> collision_r ##1 !sda_oe_r && !scl_oe_r)
    else $error("scl low before sda release not a collision");
  a_clash_release: assert property (
    collide |=> !sda_oe_r && !scl_oe_r && !any_en && is_idle)
    else $error("collision did not release lines and enables");
  a_stop_sets_irq: assert property (
    stop_evt |=> irq_r)
    else $error("bus stop did not set irq flag");
  a_flag_sticky: assert property (
    collision_r && !clear_collision |=> collision_r)
    else $error("collision flag dropped without a clear");

endmodule : cond_collide

// *** bench/bus_partner.sv ***
`timescale 1ns/1ns
// another master on the shared bus: open-drain pulls, pull-ups, optional clock stretch
module bus_partner (
  input  wire logic       clk_sys,
  input  wire logic       dut_sda_oe,
  input  wire logic       dut_scl_oe,
  input  wire logic       pull_sda,
  input  wire logic       pull_scl,
  input  wire logic [3:0] stretch,
  output logic            sda_wire,
  output logic            scl_wire
);
  logic [3:0] hold_r = 4'h0;

  // keeps scl low for stretch cycles once the device lets it go (slow answer)
  always @(posedge clk_sys) begin
    if (dut_scl_oe) begin
      hold_r <= stretch;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end

  // wired-and with pull-up: a released line floats high
  assign sda_wire = !(dut_sda_oe || pull_sda);
  assign scl_wire = !(dut_scl_oe || pull_scl || (!dut_scl_oe && hold_r != 4'h0));
endmodule : bus_partner

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic       clk_sys, clk_link;
  logic       rst_n = 1'b0;
  logic [7:0] baud_reload_value = 8'h83;
  logic       start_req = 1'b0, rstart_req = 1'b0, stop_req = 1'b0;
  logic       clear_collision = 1'b0, clear_irq = 1'b0;
  logic       pull_sda = 1'b0, pull_scl = 1'b0;
  logic [3:0] stretch = 4'h0;
  logic       sda_w, scl_w, sda_out, sda_oe, scl_out, scl_oe;
  logic       start_en, rstart_en, stop_en, bus_collision_flag, serial_port_irq_flag;
  int         errors = 0;
  int         cmp_count = 0;

  cond_collide dut_u (.clk_sys, .rst_n, .clk_link, .sda_in(sda_w), .sda_out, .sda_oe,
    .scl_in(scl_w), .scl_out, .scl_oe, .baud_reload_value, .start_req, .rstart_req,
    .stop_req, .clear_collision, .clear_irq, .start_en, .rstart_en, .stop_en,
    .bus_collision_flag, .serial_port_irq_flag);
  bus_partner partner_u (.clk_sys, .dut_sda_oe(sda_oe), .dut_scl_oe(scl_oe), .pull_sda,
    .pull_scl, .stretch, .sda_wire(sda_w), .scl_wire(scl_w));

  // system clock 40 ns, link clock 48 ns with its own phase
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #24 clk_link = ~clk_link;
  end

  // selects an observed output by number
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = sda_oe;
      1: pick = scl_oe;
      2: pick = bus_collision_flag;
      3: pick = start_en;
      4: pick = rstart_en;
      5: pick = stop_en;
      default: pick = serial_port_irq_flag;
    endcase
  endfunction : pick

  task automatic end_sim;
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // bounded wait; n is the number of edges it took
  task automatic wait_for(input int sel, input logic val, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (pick(sel) !== val && n < 300);
    if (pick(sel) !== val) begin
      errors++;
      $display("[FAIL] wait%0d expected %b seen %b", sel, val, pick(sel));
      end_sim();
    end
  endtask : wait_for

  // one-cycle pulse on a request or clear input, baud value set with it
  task automatic pulse(input int sel, input logic [7:0] baud);
    @(posedge clk_sys);
    baud_reload_value <= baud;
    start_req <= (sel == 3);
    rstart_req <= (sel == 4);
    stop_req <= (sel == 5);
    clear_collision <= (sel == 2);
    clear_irq <= (sel == 6);
    @(posedge clk_sys);
    {start_req, rstart_req, stop_req, clear_collision, clear_irq} <= 5'h00;
  endtask : pulse

  task automatic drive(input logic sda_p, input logic scl_p);
    @(posedge clk_sys);
    pull_sda <= sda_p;
    pull_scl <= scl_p;
  endtask : drive

  // collision seen: condition aborted, lines released, flag then cleared
  task automatic coll(input int en);
    int n;
    wait_for(2, 1'b1, n);
    cyc(1);
    chk("enable", pick(en), 1'b0);
    chk("sda_oe", sda_oe, 1'b0);
    chk("scl_oe", scl_oe, 1'b0);
    drive(1'b0, 1'b0);
    pulse(2, 8'h83);
  endtask : coll

  // clean start, bit 7 of the reload ignored, scl dip in second count harmless
  task automatic t_start_clean;
    int n;
    cyc(6); // released lines settle through the synchronisers
    pulse(3, 8'h8B);
    wait_for(0, 1'b1, n);
    fork
      wait_for(1, 1'b1, n);
      begin
        drive(1'b0, 1'b1);
        cyc(3);
        drive(1'b0, 1'b0);
      end
    join
    chk("gap", 8'(n), 8'h0C);
    wait_for(3, 1'b0, n);
    chk("flag", bus_collision_flag, 1'b0);
    chk("scl_oe", scl_oe, 1'b1);
    chk("sda_out", sda_out, 1'b0);
    chk("scl_out", scl_out, 1'b0);
  endtask : t_start_clean

  // start on a busy bus; flag sticky until cleared; bus stop afterwards raises irq
  task automatic t_start_busy;
    int n;
    pulse(6, 8'h83);
    drive(1'b1, 1'b0);
    cyc(8);
    pulse(3, 8'h83);
    wait_for(2, 1'b1, n);
    chk("start_en", start_en, 1'b0);
    chk("sda_oe", sda_oe, 1'b0);
    cyc(20);
    chk("flag", bus_collision_flag, 1'b1);
    drive(1'b0, 1'b0);
    wait_for(6, 1'b1, n);
    pulse(2, 8'h83);
    pulse(6, 8'h83);
    cyc(2);
    chk("flag", bus_collision_flag, 1'b0);
    chk("irq", serial_port_irq_flag, 1'b0);
  endtask : t_start_busy

  task automatic t_start_scl_low;
    int n;
    pulse(3, 8'h8F);
    wait_for(3, 1'b1, n);
    cyc(4);
    drive(1'b0, 1'b1);
    coll(3);
  endtask : t_start_scl_low

  // sda taken by the other master: pulled early, no collision
  task automatic t_start_sda_low;
    int n;
    pulse(3, 8'h8F);
    wait_for(3, 1'b1, n);
    cyc(4);
    drive(1'b1, 1'b0);
    wait_for(0, 1'b1, n);
    chk("early", (n < 10), 1'b1);
    drive(1'b0, 1'b0);
    wait_for(3, 0, n);
    chk("flag", bus_collision_flag, 1'b0);
  endtask : t_start_sda_low

  // repeated start with an sda dip in the reloaded count
  task automatic t_rstart_dip;
    int n;
    pulse(4, 8'h8F);
    wait_for(0, 1'b0, n);
    wait_for(1, 1'b0, n);
    chk("count", (n > 15), 1'b1);
    cyc(8);
    drive(1'b1, 1'b0);
    cyc(3);
    drive(1'b0, 1'b0);
    wait_for(4, 1'b0, n);
    chk("flag", bus_collision_flag, 1'b0);
    chk("sda_oe", sda_oe, 1'b1);
    chk("scl_oe", scl_oe, 1'b1);
  endtask : t_rstart_dip

  task automatic t_rstart_coll;
    int n;
    // sda taken while scl is still held, so it is low when scl is seen high
    pulse(4, 8'h8B);
    wait_for(0, 1'b0, n);
    cyc(8);
    drive(1'b1, 1'b0);
    coll(4);
    t_start_clean();
    pulse(4, 8'h8F);
    wait_for(1, 1'b0, n);
    cyc(8);
    drive(1'b0, 1'b1);
    coll(4);
  endtask : t_rstart_coll

  // stop after the repeated start, other master stretching scl
  task automatic t_stop_stretch;
    int n;
    pulse(6, 8'h83);
    stretch <= 4'h6;
    pulse(5, 8'h8B);
    wait_for(1, 1'b0, n);
    wait_for(0, 1'b0, n);
    chk("wait", (n >= 20), 1'b1);
    wait_for(5, 1'b0, n);
    chk("flag", bus_collision_flag, 1'b0);
    chk("irq", serial_port_irq_flag, 1'b1);
    stretch <= 4'h0;
  endtask : t_stop_stretch

  task automatic t_stop_coll;
    int n;
    t_start_clean();
    pulse(5, 8'h83);
    wait_for(1, 1'b0, n);
    drive(1'b1, 1'b0);
    coll(5);
    t_start_clean();
    pulse(5, 8'h8F);
    wait_for(1, 1'b0, n);
    cyc(6);
    drive(1'b0, 1'b1);
    coll(5);
  endtask : t_stop_coll

  // stop made by the other master alone
  task automatic t_bus_stop;
    int n;
    pulse(6, 8'h83);
    drive(1'b1, 1'b0);
    cyc(8);
    drive(1'b0, 1'b0);
    wait_for(6, 1'b1, n);
    chk("irq", serial_port_irq_flag, 1'b1);
  endtask : t_bus_stop

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(8);
    t_start_clean();
    t_rstart_dip();
    t_stop_stretch();
    t_start_busy();
    t_start_scl_low();
    t_start_sda_low();
    t_rstart_coll();
    t_stop_coll();
    t_bus_stop();
    end_sim();
  end
endmodule : tb
